// File: design/gwd_params.svh
// Register offsets, field positions and reset values of the graphics datapath
`ifndef GWD_PARAMS_SVH
`define GWD_PARAMS_SVH

// ------------------------------------------------------------
// I/O ports
// ------------------------------------------------------------
`define GWD_INDEX_PORT     16'h03ce
`define GWD_DATA_PORT      16'h03cf

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define GWD_IDX_FILL_VAL   4'h0
`define GWD_IDX_FILL_EN    4'h1
`define GWD_IDX_CMP_COLOR  4'h2
`define GWD_IDX_ROT_OP     4'h3
`define GWD_IDX_RD_PLANE   4'h4
`define GWD_IDX_GFX_MODE   4'h5
`define GWD_IDX_MISC       4'h6
`define GWD_IDX_CMP_INCL   4'h7
`define GWD_IDX_BIT_MASK   4'h8

// ------------------------------------------------------------
// Implemented bits per register (others read zero)
// ------------------------------------------------------------
`define GWD_MASK_INDEX     8'h0f
`define GWD_MASK_PLANE4    8'h0f
`define GWD_MASK_ROT_OP    8'h1f
`define GWD_MASK_RD_PLANE  8'h03
`define GWD_MASK_GFX_MODE  8'h7b
`define GWD_MASK_FULL      8'hff

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define GWD_ROT_CNT_LSB    0
`define GWD_ROT_CNT_MSB    2
`define GWD_FUNC_LSB       3
`define GWD_FUNC_MSB       4
`define GWD_WMODE_LSB      0
`define GWD_WMODE_MSB      1
`define GWD_RMODE_BIT      3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define GWD_RST_INDEX      8'h00
`define GWD_RST_REG        8'h00
`define GWD_RST_BIT_MASK   8'hff

`endif

// File: design/gwd_pkg.sv
// Types shared by the graphics write/read datapath
`default_nettype none

package gwd_pkg;

  // Write modes of the graphics mode register
  typedef enum logic [1:0] {
    GWD_WM0 = 2'h0,
    GWD_WM1 = 2'h1,
    GWD_WM2 = 2'h2,
    GWD_WM3 = 2'h3
  } gwd_wmode_t;

  // Logical function against the read latch
  typedef enum logic [1:0] {
    GWD_OP_PASS = 2'h0,
    GWD_OP_AND  = 2'h1,
    GWD_OP_OR   = 2'h2,
    GWD_OP_XOR  = 2'h3
  } gwd_logic_op_t;

endpackage : gwd_pkg

`default_nettype wire

// File: design/gwd_read_path.sv
// Read datapath: plane select or color compare
`timescale 1ns/1ps
`default_nettype none

module gwd_read_path (
  // Plane bytes at the read address
  input  wire logic [31:0] plane_rdata,
  // Control fields
  input  wire logic        read_mode,
  input  wire logic [1:0]  read_plane,
  input  wire logic [3:0]  compare_color,
  input  wire logic [3:0]  compare_include,
  // CPU result
  output logic      [7:0]  cpu_byte
);

  // ------------------------------------------------------------
  // Compare and select
  // ------------------------------------------------------------
  logic [7:0] cmp_result;
  logic [7:0] plane_byte;

  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : g_bit
      logic [3:0] col;
      assign col = {plane_rdata[24+b], plane_rdata[16+b], plane_rdata[8+b], plane_rdata[b]};
      // Match in every included plane
      assign cmp_result[b] = &(~(col ^ compare_color) | ~compare_include);
    end
  endgenerate

  assign plane_byte = plane_rdata[read_plane*8 +: 8];
  assign cpu_byte   = read_mode ? cmp_result : plane_byte;

endmodule : gwd_read_path

`default_nettype wire

// File: design/gwd_top.sv
// Graphics controller register bank and frame buffer datapath
`timescale 1ns/1ps
`default_nettype none
`include "gwd_params.svh"

module gwd_top (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // Host I/O port
  input  wire logic [15:0] IO_ADDR,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [7:0]  IO_WDATA,
  output logic      [7:0]  IO_RDATA,
  output logic             IO_RVALID,
  // Host frame buffer access
  input  wire logic        CPU_MEM_WR,
  input  wire logic        CPU_MEM_RD,
  input  wire logic [7:0]  CPU_WDATA,
  output logic      [7:0]  CPU_RDATA,
  output logic             CPU_RVALID,
  // Sequencer plane write mask
  input  wire logic [3:0]  PLANE_WRITE_MASK,
  // Frame buffer planes
  input  wire logic [31:0] FB_RDATA,
  output logic      [31:0] FB_WDATA,
  output logic      [3:0]  FB_PLANE_WE,
  output logic             FB_WR
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0]  gfx_index;
  logic [7:0]  plane_fill_value;
  logic [7:0]  plane_fill_enable;
  logic [7:0]  compare_color;
  logic [7:0]  rotate_and_logic_op;
  logic [7:0]  read_plane_choice;
  logic [7:0]  graphics_mode_ctl;
  logic [7:0]  misc_ctl;
  logic [7:0]  compare_plane_include;
  logic [7:0]  write_bit_mask;
  logic [31:0] read_latch;

  // ------------------------------------------------------------
  // Port decode
  // ------------------------------------------------------------
  logic       hit_index;
  logic       hit_data;
  logic       wr_index;
  logic       wr_data;
  logic [3:0] sel;
  logic       sel_valid;

  // Index and data port strobes
  assign hit_index = (IO_ADDR == `GWD_INDEX_PORT);
  assign hit_data  = (IO_ADDR == `GWD_DATA_PORT);
  assign wr_index  = IO_WR & hit_index;
  assign wr_data   = IO_WR & hit_data;
  // Only the low nibble selects a register
  assign sel       = gfx_index[3:0];
  assign sel_valid = (sel <= `GWD_IDX_BIT_MASK);

  // Per-register write enables
  logic we_fill_val;
  logic we_fill_en;
  logic we_cmp_color;
  logic we_rot_op;
  logic we_rd_plane;
  logic we_mode;
  logic we_misc;
  logic we_cmp_incl;
  logic we_bit_mask;

  assign we_fill_val  = wr_data & (sel == `GWD_IDX_FILL_VAL);
  assign we_fill_en   = wr_data & (sel == `GWD_IDX_FILL_EN);
  assign we_cmp_color = wr_data & (sel == `GWD_IDX_CMP_COLOR);
  assign we_rot_op    = wr_data & (sel == `GWD_IDX_ROT_OP);
  assign we_rd_plane  = wr_data & (sel == `GWD_IDX_RD_PLANE);
  assign we_mode      = wr_data & (sel == `GWD_IDX_GFX_MODE);
  assign we_misc      = wr_data & (sel == `GWD_IDX_MISC);
  assign we_cmp_incl  = wr_data & (sel == `GWD_IDX_CMP_INCL);
  assign we_bit_mask  = wr_data & (sel == `GWD_IDX_BIT_MASK);

  // ------------------------------------------------------------
  // Next register values, reserved bits held at zero
  // ------------------------------------------------------------
  logic [7:0] next_gfx_index;
  logic [7:0] next_fill_value;
  logic [7:0] next_fill_enable;
  logic [7:0] next_compare_color;
  logic [7:0] next_rotate_op;
  logic [7:0] next_read_plane;
  logic [7:0] next_mode;
  logic [7:0] next_misc;
  logic [7:0] next_cmp_incl;
  logic [7:0] next_bit_mask;

  assign next_gfx_index     = wr_index ? (IO_WDATA & `GWD_MASK_INDEX) : gfx_index;
  assign next_fill_value    = we_fill_val ? (IO_WDATA & `GWD_MASK_PLANE4) : plane_fill_value;
  assign next_fill_enable   = we_fill_en ? (IO_WDATA & `GWD_MASK_PLANE4) : plane_fill_enable;
  assign next_compare_color = we_cmp_color ? (IO_WDATA & `GWD_MASK_PLANE4) : compare_color;
  assign next_rotate_op     = we_rot_op ? (IO_WDATA & `GWD_MASK_ROT_OP) : rotate_and_logic_op;
  assign next_read_plane    = we_rd_plane ? (IO_WDATA & `GWD_MASK_RD_PLANE) : read_plane_choice;
  assign next_mode          = we_mode ? (IO_WDATA & `GWD_MASK_GFX_MODE) : graphics_mode_ctl;
  assign next_misc          = we_misc ? (IO_WDATA & `GWD_MASK_FULL) : misc_ctl;
  assign next_cmp_incl      = we_cmp_incl ? (IO_WDATA & `GWD_MASK_PLANE4) : compare_plane_include;
  assign next_bit_mask      = we_bit_mask ? IO_WDATA : write_bit_mask;

  // Index register
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      gfx_index <= `GWD_RST_INDEX;
    else
      gfx_index <= next_gfx_index;
  end

  // Data registers
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      plane_fill_value      <= `GWD_RST_REG;
      plane_fill_enable     <= `GWD_RST_REG;
      compare_color         <= `GWD_RST_REG;
      rotate_and_logic_op   <= `GWD_RST_REG;
      read_plane_choice     <= `GWD_RST_REG;
      graphics_mode_ctl     <= `GWD_RST_REG;
      misc_ctl              <= `GWD_RST_REG;
      compare_plane_include <= `GWD_RST_REG;
      write_bit_mask        <= `GWD_RST_BIT_MASK;
    end
    else
    begin
      plane_fill_value      <= next_fill_value;
      plane_fill_enable     <= next_fill_enable;
      compare_color         <= next_compare_color;
      rotate_and_logic_op   <= next_rotate_op;
      read_plane_choice     <= next_read_plane;
      graphics_mode_ctl     <= next_mode;
      misc_ctl              <= next_misc;
      compare_plane_include <= next_cmp_incl;
      write_bit_mask        <= next_bit_mask;
    end
  end

  // ------------------------------------------------------------
  // Register read-back
  // ------------------------------------------------------------
  logic [7:0] data_port_val;
  logic [7:0] next_io_rdata;

  // Selected register, zero beyond index eight
  assign data_port_val =
    !sel_valid                        ? 8'h00 :
    (sel == `GWD_IDX_FILL_VAL)        ? plane_fill_value :
    (sel == `GWD_IDX_FILL_EN)         ? plane_fill_enable :
    (sel == `GWD_IDX_CMP_COLOR)       ? compare_color :
    (sel == `GWD_IDX_ROT_OP)          ? rotate_and_logic_op :
    (sel == `GWD_IDX_RD_PLANE)        ? read_plane_choice :
    (sel == `GWD_IDX_GFX_MODE)        ? graphics_mode_ctl :
    (sel == `GWD_IDX_MISC)            ? misc_ctl :
    (sel == `GWD_IDX_CMP_INCL)        ? compare_plane_include :
    write_bit_mask;

  // Port mux; unmapped address returns zero
  assign next_io_rdata = hit_index ? gfx_index :
                         hit_data  ? data_port_val : 8'h00;

  // Registered read answer
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      IO_RDATA  <= 8'h00;
      IO_RVALID <= 1'b0;
    end
    else
    begin
      IO_RDATA  <= IO_RD ? next_io_rdata : IO_RDATA;
      IO_RVALID <= IO_RD;
    end
  end

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  gwd_pkg::gwd_wmode_t    wmode;
  gwd_pkg::gwd_logic_op_t logic_op;
  logic [2:0]             rot_count;
  logic                   read_mode;

  assign wmode     = gwd_pkg::gwd_wmode_t'(graphics_mode_ctl[`GWD_WMODE_MSB:`GWD_WMODE_LSB]);
  assign logic_op  = gwd_pkg::gwd_logic_op_t'(rotate_and_logic_op[`GWD_FUNC_MSB:`GWD_FUNC_LSB]);
  assign rot_count = rotate_and_logic_op[`GWD_ROT_CNT_MSB:`GWD_ROT_CNT_LSB];
  assign read_mode = graphics_mode_ctl[`GWD_RMODE_BIT];

  // ------------------------------------------------------------
  // Write datapath
  // ------------------------------------------------------------
  logic [31:0] wr_result;

  gwd_write_path u_write_path (
    .cpu_data    (CPU_WDATA),
    .latch       (read_latch),
    .fill_value  (plane_fill_value[3:0]),
    .fill_enable (plane_fill_enable[3:0]),
    .rot_count   (rot_count),
    .logic_op    (logic_op),
    .wmode       (wmode),
    .bit_mask    (write_bit_mask),
    .plane_data  (wr_result)
  );

  // Frame buffer write, planes gated by write mask
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      FB_WR       <= 1'b0;
      FB_WDATA    <= 32'h0000_0000;
      FB_PLANE_WE <= 4'h0;
    end
    else
    begin
      FB_WR       <= CPU_MEM_WR;
      FB_WDATA    <= CPU_MEM_WR ? wr_result : FB_WDATA;
      FB_PLANE_WE <= CPU_MEM_WR ? PLANE_WRITE_MASK : 4'h0;
    end
  end

  // ------------------------------------------------------------
  // Read datapath and latch
  // ------------------------------------------------------------
  logic [7:0] rd_result;

  gwd_read_path u_read_path (
    .plane_rdata     (FB_RDATA),
    .read_mode       (read_mode),
    .read_plane      (read_plane_choice[1:0]),
    .compare_color   (compare_color[3:0]),
    .compare_include (compare_plane_include[3:0]),
    .cpu_byte        (rd_result)
  );

  // Latch all planes and answer the CPU
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      read_latch <= 32'h0000_0000;
      CPU_RDATA  <= 8'h00;
      CPU_RVALID <= 1'b0;
    end
    else
    begin
      read_latch <= CPU_MEM_RD ? FB_RDATA : read_latch;
      CPU_RDATA  <= CPU_MEM_RD ? rd_result : CPU_RDATA;
      CPU_RVALID <= CPU_MEM_RD;
    end
  end

endmodule : gwd_top

`default_nettype wire

// File: design/gwd_write_path.sv
// Write datapath: rotate, set/reset, latch function, bit mask merge
`timescale 1ns/1ps
`default_nettype none

module gwd_write_path (
  // CPU data and latch
  input  wire logic [7:0]            cpu_data,
  input  wire logic [31:0]           latch,
  // Control fields
  input  wire logic [3:0]            fill_value,
  input  wire logic [3:0]            fill_enable,
  input  wire logic [2:0]            rot_count,
  input  wire gwd_pkg::gwd_logic_op_t logic_op,
  input  wire gwd_pkg::gwd_wmode_t   wmode,
  input  wire logic [7:0]            bit_mask,
  // Result per plane
  output logic      [31:0]           plane_data
);

  // ------------------------------------------------------------
  // Rotation stage
  // ------------------------------------------------------------
  logic [15:0] dbl_shift;
  logic [7:0]  rotated;
  logic [7:0]  eff_mask;

  // Rotate right by count
  assign dbl_shift = {cpu_data, cpu_data} >> rot_count;
  assign rotated   = dbl_shift[7:0];
  // Mode 3 ANDs rotated data with the bit mask to form the per-bit mask
  assign eff_mask  = (wmode == gwd_pkg::GWD_WM3) ? (rotated & bit_mask) : bit_mask;

  // Latch logical function
  function automatic logic [7:0] apply_op(input gwd_pkg::gwd_logic_op_t op,
                                          input logic [7:0] d,
                                          input logic [7:0] l);
    unique case (op)
      gwd_pkg::GWD_OP_PASS: apply_op = d;
      gwd_pkg::GWD_OP_AND:  apply_op = d & l;
      gwd_pkg::GWD_OP_OR:   apply_op = d | l;
      gwd_pkg::GWD_OP_XOR:  apply_op = d ^ l;
    endcase
  endfunction : apply_op

  // ------------------------------------------------------------
  // Per-plane stages, in fixed order
  // ------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1)
    begin : g_plane
      logic [7:0] lat;
      logic [7:0] src;
      logic [7:0] alu;
      logic [7:0] merged;
      assign lat = latch[p*8 +: 8];
      // Set/reset substitution after rotation
      assign src =
        (wmode == gwd_pkg::GWD_WM0) ?
          (fill_enable[p] ? {8{fill_value[p]}} : rotated) :
        (wmode == gwd_pkg::GWD_WM3) ? {8{fill_value[p]}} :
        {8{cpu_data[p]}};
      assign alu    = apply_op(logic_op, src, lat);
      // Bit mask merge with latch comes last
      assign merged = (alu & eff_mask) | (lat & ~eff_mask);
      // Mode 1 copies the latches unchanged
      assign plane_data[p*8 +: 8] = (wmode == gwd_pkg::GWD_WM1) ? lat : merged;
    end
  endgenerate

endmodule : gwd_write_path

`default_nettype wire

// File: testbench/gwd_checker.sv
// Port checker for the graphics datapath top
`timescale 1ns/1ps
`default_nettype none
`include "gwd_params.svh"

module gwd_checker (
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  // Host I/O port
  input wire logic [15:0] IO_ADDR,
  input wire logic        IO_WR,
  input wire logic        IO_RD,
  input wire logic [7:0]  IO_WDATA,
  input wire logic [7:0]  IO_RDATA,
  input wire logic        IO_RVALID,
  // Frame buffer access
  input wire logic        CPU_MEM_WR,
  input wire logic        CPU_MEM_RD,
  input wire logic [7:0]  CPU_RDATA,
  input wire logic        CPU_RVALID,
  input wire logic [3:0]  PLANE_WRITE_MASK,
  input wire logic [31:0] FB_WDATA,
  input wire logic [3:0]  FB_PLANE_WE,
  input wire logic        FB_WR
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  // Register port timing and contents
  property p_io_rvalid;
    1'b1 |=> IO_RVALID == $past(IO_RD);
  endproperty
  a_io_rvalid: assert property (p_io_rvalid) else $error("io read answer off");
  property p_idx_reserved;
    (IO_WR && IO_ADDR == `GWD_INDEX_PORT && IO_WDATA[3:0] > 4'h8)
      ##2 (IO_RD && IO_ADDR == `GWD_DATA_PORT) |=> IO_RDATA == 8'h00;
  endproperty
  a_idx_reserved: assert property (p_idx_reserved) else $error("empty index read");
  property p_idx_readback;
    (IO_WR && IO_ADDR == `GWD_INDEX_PORT) ##2 (IO_RD && IO_ADDR == `GWD_INDEX_PORT)
      |=> IO_RDATA == {4'h0, $past(IO_WDATA[3:0], 3)};
  endproperty
  a_idx_readback: assert property (p_idx_readback) else $error("index readback");
  property p_rdata_hold;
    !IO_RVALID |-> $stable(IO_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("io data moved");

  // Frame buffer write and read timing
  property p_fb_wr;
    1'b1 |=> FB_WR == $past(CPU_MEM_WR);
  endproperty
  a_fb_wr: assert property (p_fb_wr) else $error("write strobe off");
  property p_plane_we;
    CPU_MEM_WR |=> FB_PLANE_WE == $past(PLANE_WRITE_MASK);
  endproperty
  a_plane_we: assert property (p_plane_we) else $error("plane enables wrong");
  property p_we_idle;
    !FB_WR |-> FB_PLANE_WE == 4'h0;
  endproperty
  a_we_idle: assert property (p_we_idle) else $error("enables without strobe");
  property p_wdata_hold;
    !FB_WR |-> $stable(FB_WDATA);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("plane data moved");
  property p_cpu_rvalid;
    1'b1 |=> CPU_RVALID == $past(CPU_MEM_RD);
  endproperty
  a_cpu_rvalid: assert property (p_cpu_rvalid) else $error("frame read answer off");
  property p_cpu_rdata_hold;
    !CPU_RVALID |-> $stable(CPU_RDATA);
  endproperty
  a_cpu_rdata_hold: assert property (p_cpu_rdata_hold) else $error("frame data moved");
endmodule : gwd_checker

bind gwd_top gwd_checker i_gwd_checker (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
  .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
  .CPU_MEM_WR(CPU_MEM_WR), .CPU_MEM_RD(CPU_MEM_RD), .CPU_RDATA(CPU_RDATA),
  .CPU_RVALID(CPU_RVALID), .PLANE_WRITE_MASK(PLANE_WRITE_MASK), .FB_WDATA(FB_WDATA),
  .FB_PLANE_WE(FB_PLANE_WE), .FB_WR(FB_WR)
);
`default_nettype wire

// File: testbench/gwd_fb_model.sv
// Frame buffer model: the addressed byte of each of four planes
`timescale 1ns/1ps
`default_nettype none

module gwd_fb_model #(
  parameter logic [31:0] INIT = 32'hc35a963c
) (
  // Clock
  input  wire logic        sys_clk,
  // Write side
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  plane_we,
  input  wire logic        wr,
  // Read side, always valid
  output logic      [31:0] rdata
);
  logic [31:0] mem = INIT;

  // Store enabled plane bytes only
  always @(posedge sys_clk)
  begin
    for (int p = 0; p < 4; p++)
      if (wr && plane_we[p])
        mem[8*p +: 8] <= wdata[8*p +: 8];
  end
  assign rdata = mem;
endmodule : gwd_fb_model
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the graphics write/read datapath
`timescale 1ns/1ps
`default_nettype none
`include "gwd_params.svh"

module tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        sys_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic [15:0] io_addr   = 16'h0000;
  logic        io_wr     = 1'b0;
  logic        io_rd     = 1'b0;
  logic [7:0]  io_wdata  = 8'h00;
  logic        mem_wr    = 1'b0;
  logic        mem_rd    = 1'b0;
  logic [7:0]  cpu_wdata = 8'h00;
  logic [3:0]  pmask     = 4'h0;
  logic [7:0]  io_rdata, cpu_rdata;
  logic        io_rvalid, cpu_rvalid, fb_wr;
  logic [31:0] fb_rdata, fb_wdata;
  logic [3:0]  fb_we;
  logic [31:0] fb_exp    = 32'hc35a963c;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          cyc       = 0;

  always #2.5 sys_clk = ~sys_clk;

  gwd_top i_gwd_top (
    .SYS_CLK(sys_clk), .RESET(reset), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid),
    .CPU_MEM_WR(mem_wr), .CPU_MEM_RD(mem_rd), .CPU_WDATA(cpu_wdata),
    .CPU_RDATA(cpu_rdata), .CPU_RVALID(cpu_rvalid), .PLANE_WRITE_MASK(pmask),
    .FB_RDATA(fb_rdata), .FB_WDATA(fb_wdata), .FB_PLANE_WE(fb_we), .FB_WR(fb_wr)
  );
  gwd_fb_model i_gwd_fb_model (
    .sys_clk(sys_clk), .wdata(fb_wdata), .plane_we(fb_we), .wr(fb_wr), .rdata(fb_rdata)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic test_done;
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // Expected plane bytes of one mode 0 or mode 3 frame buffer write, fill value 8'h05
  function automatic logic [31:0] ref_wr(input logic [1:0] wm, input logic [7:0] d,
    input logic [31:0] lat, input logic [3:0] en, input logic [4:0] ro,
    input logic [7:0] bm);
    logic [15:0] t;
    logic [7:0]  rot, src, a, m, l;
    logic [31:0] res;
    t   = {d, d} >> ro[2:0];
    rot = t[7:0];
    m   = (wm == 2'h3) ? (rot & bm) : bm;
    for (int p = 0; p < 4; p++)
    begin
      l   = lat[8*p +: 8];
      src = (wm == 2'h3 || en[p]) ? {8{p == 0 || p == 2}} : rot;
      case (ro[4:3])
        2'h0:    a = src;
        2'h1:    a = src & l;
        2'h2:    a = src | l;
        default: a = src ^ l;
      endcase
      res[8*p +: 8] = (a & m) | (l & ~m);
    end
    return res;
  endfunction : ref_wr

  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr    <= 1'b0;
  endtask : io_write

  task automatic io_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge sys_clk);
    io_rd   <= 1'b0;
    #1;
    d = io_rdata;
  endtask : io_read

  task automatic wreg(input logic [3:0] i, input logic [7:0] v);
    io_write(`GWD_INDEX_PORT, {4'h0, i});
    io_write(`GWD_DATA_PORT, v);
  endtask : wreg

  task automatic rreg(input logic [3:0] i, input logic [7:0] e);
    logic [7:0] d;
    io_write(`GWD_INDEX_PORT, {4'h0, i});
    io_read(`GWD_DATA_PORT, d);
    chk(d, e);
  endtask : rreg

  task automatic mem_write(input logic [7:0] d, input logic [3:0] pm);
    @(posedge sys_clk);
    cpu_wdata <= d;
    pmask     <= pm;
    mem_wr    <= 1'b1;
    @(posedge sys_clk);
    mem_wr    <= 1'b0;
    #1;
  endtask : mem_write

  task automatic mem_read(output logic [7:0] d);
    @(posedge sys_clk);
    mem_rd <= 1'b1;
    @(posedge sys_clk);
    mem_rd <= 1'b0;
    #1;
    d = cpu_rdata;
  endtask : mem_read

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    io_read(`GWD_INDEX_PORT, d);
    chk(d, 8'h00);
    rreg(`GWD_IDX_BIT_MASK, 8'hff);
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] msk [9] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'hff, 8'h0f, 8'hff};
    logic [7:0] d;
    for (int i = 0; i < 9; i++)
    begin
      wreg(i[3:0], 8'hff);
      rreg(i[3:0], msk[i]);
    end
    wreg(4'h9, 8'h5a);
    rreg(4'h9, 8'h00);
    io_write(`GWD_INDEX_PORT, 8'hf3);
    io_read(`GWD_INDEX_PORT, d);
    chk(d, 8'h03);
    io_read(16'h03cd, d);
    chk(d, 8'h00);
  endtask : t_regs

  // Mode 0, every function code, partial plane mask
  task automatic t_write;
    logic [7:0]  d;
    logic [4:0]  ro;
    logic [31:0] e;
    wreg(`GWD_IDX_BIT_MASK, 8'h7e);
    wreg(`GWD_IDX_FILL_VAL, 8'h05);
    wreg(`GWD_IDX_FILL_EN, 8'h03);
    wreg(`GWD_IDX_GFX_MODE, 8'h00);
    for (int op = 0; op < 4; op++)
    begin
      ro = {op[1:0], 3'(2 * op + 1)};
      wreg(`GWD_IDX_ROT_OP, {3'h0, ro});
      mem_read(d);
      e = ref_wr(2'h0, 8'hb4, fb_exp, 4'h3, ro, 8'h7e);
      mem_write(8'hb4, 4'ha);
      chk(fb_wdata, e);
      chk(fb_we, 4'ha);
      fb_exp = {e[31:24], fb_exp[23:16], e[15:8], fb_exp[7:0]};
    end
    mem_read(d);
    chk(fb_rdata, fb_exp);
  endtask : t_write

  // Mode 3 with fill enables off
  task automatic t_mode3;
    logic [7:0]  d;
    logic [31:0] e;
    wreg(`GWD_IDX_FILL_EN, 8'h00);
    wreg(`GWD_IDX_ROT_OP, 8'h02);
    wreg(`GWD_IDX_GFX_MODE, 8'h03);
    mem_read(d);
    e = ref_wr(2'h3, 8'hb1, fb_exp, 4'h0, 5'h02, 8'h7e);
    mem_write(8'hb1, 4'hf);
    chk(fb_wdata, e);
    fb_exp = e;
    // Modes 2 and 1 ignore the fill enables; nothing is stored
    wreg(`GWD_IDX_FILL_EN, 8'h0f);
    wreg(`GWD_IDX_GFX_MODE, 8'h02);
    mem_read(d);
    for (int p = 0; p < 4; p++)
      e[8*p +: 8] = ({8{p == 0 || p == 2}} & 8'h7e) | (fb_exp[8*p +: 8] & 8'h81);
    mem_write(8'h05, 4'h0);
    chk(fb_wdata, e);
    wreg(`GWD_IDX_GFX_MODE, 8'h01);
    mem_read(d);
    mem_write(8'h05, 4'h0);
    chk(fb_wdata, fb_exp);
  endtask : t_mode3

  task automatic t_read;
    logic [7:0] d, e;
    wreg(`GWD_IDX_GFX_MODE, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      wreg(`GWD_IDX_RD_PLANE, 8'(p));
      mem_read(d);
      chk(d, fb_exp[8*p +: 8]);
    end
    wreg(`GWD_IDX_GFX_MODE, 8'h08);
    wreg(`GWD_IDX_CMP_COLOR, 8'h06);
    for (int k = 0; k < 2; k++)
    begin
      wreg(`GWD_IDX_CMP_INCL, k ? 8'h0b : 8'h00);
      e = 8'hff;
      for (int p = 0; p < 4; p++)
        if (k && p != 2)
          e &= ~(fb_exp[8*p +: 8] ^ {8{p == 1}});
      mem_read(d);
      chk(d, e);
    end
  endtask : t_read

  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      test_done();
    end
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_write();
    t_mode3();
    t_read();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
